//--- hdl/ingress_rate_limit_config_defines.vh
`ifndef INGRESS_RATE_LIMIT_CONFIG_DEFINES_VH
`define INGRESS_RATE_LIMIT_CONFIG_DEFINES_VH

// register indices; byte address is four times the index
`define PORT2_PRIO1_LIMIT_IDX 8'hc8
`define PORT3_PRIO1_LIMIT_IDX 8'hd8
`define PORT4_PRIO0_LIMIT_IDX 8'he7
`define PORT1_CTRL_IDX        8'hb6
`define PORT_STRIDE           8'h10
`define SLOTS_PER_PORT        4'h5

// slots within one port's group
`define SLOT_CTRL   4'h0
`define SLOT_PRIO0  4'h1
`define SLOT_PRIO3  4'h4

// rate limit control fields
`define CTRL_PORT_BASED_BIT 6
`define CTRL_PACKET_BIT     5
`define CTRL_FLOW_BIT       4
`define CTRL_MODE_HI        3
`define CTRL_MODE_LO        2
`define CTRL_IFG_BIT        1
`define CTRL_PREAMBLE_BIT   0
`define CTRL_RESET          8'h00
`define CTRL_WR_MASK        8'h7f

// limit registers
`define LIMIT_EN_BIT  7
`define LIMIT_RESET   7'h00

// frame class modes
`define MODE_ALL        2'h0
`define MODE_BC_MC_FLD  2'h1
`define MODE_BC_MC      2'h2
`define MODE_BC         2'h3

// per-frame overhead in bytes
`define IFG_BYTES       5'h0c
`define PREAMBLE_BYTES  5'h08

`endif

//--- hdl/ingress_rate_limit_config.v
// Functional notes
// (R1) mode 00 all, 01 bcast/mcast/flooded, 10 bcast/mcast, 11 bcast; reset 00
// (R2) ifg bit adds 12 bytes per frame to ingress and egress counts
// (R3) preamble bit adds 8 bytes per frame to ingress and egress counts
// (R4) 7-bit priority-0 limit per port, reset zero, bit 7 reads zero
// (R5) 7-bit priority-1 limit per port, reset zero, bit 7 reads zero
// (R6) select bit: set means port-based limiting, clear means priority-based
// (R7) unit bit: set counts packets, clear counts bits; reset clear; the code counts bytes when clear
// (R8) any priority-3 limit write applies all four limits of that port
// (R9) frames outside the selected class pass and add nothing to counts
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/100ps
`include "ingress_rate_limit_config_defines.vh"

module ingress_rate_limit_config
#(
    parameter NPORTS = 5,
    parameter LEN_W  = 11
)
(
    input  wire              clock,
    input  wire              rst_b,
    // ahb-lite slave
    input  wire              hsel,
    input  wire [31:0]       haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire [31:0]       hwdata,
    input  wire              hready,
    output wire              hreadyout,
    output wire              hresp,
    output reg  [31:0]       hrdata,
    // ingress frame descriptor
    input  wire              frm_valid,
    input  wire [2:0]        frm_port,
    input  wire [1:0]        frm_prio,
    input  wire [LEN_W-1:0]  frm_len,
    input  wire              frm_bcast,
    input  wire              frm_mcast,
    input  wire              frm_flood,
    // ingress accounting result
    output reg               acct_valid,
    output reg  [2:0]        acct_port,
    output reg               acct_in_class,
    output reg  [LEN_W:0]    acct_amount,
    output reg  [6:0]        acct_limit,
    output reg               acct_limit_en,
    output reg               acct_flow_ctrl,
    // egress frame descriptor and result
    input  wire              egr_valid,
    input  wire [2:0]        egr_port,
    input  wire [LEN_W-1:0]  egr_len,
    output reg               egr_acct_valid,
    output reg  [LEN_W:0]    egr_acct_amount
);

localparam NLIM = NPORTS * 4;

// per-port control and limit storage
// limits are staged by writes and go live on a priority-3 write
reg  [7:0]        ctrl_r    [0:NPORTS-1];
reg               en_r      [0:NPORTS-1];
reg  [6:0]        pend_r    [0:NLIM-1];
reg  [6:0]        applied_r [0:NLIM-1];

// bus pipeline
reg               wr_pend_r;
reg               rd_pend_r;
reg  [7:0]        idx_r;

wire              addr_phase;
wire [7:0]        off_w;
wire [2:0]        port_w;
wire [3:0]        slot_w;
wire              hit_w;
reg  [7:0]        rd_value;

integer           i;

// offset of an index from the first port's group
function [7:0] reg_off;
    input [7:0] idx;
    begin
        reg_off = idx - `PORT1_CTRL_IDX;
    end
endfunction

// index lies inside some port's group of five
// slots past the fifth and ports past the last decode as unmapped
function reg_hit;
    input [7:0] idx;
    reg   [7:0] o;
    begin
        o = reg_off(idx);
        reg_hit = (idx >= `PORT1_CTRL_IDX)
                  && (o[7:4] < NPORTS)
                  && (o[3:0] < `SLOTS_PER_PORT);
    end
endfunction

// flat position of a port's limit for one priority
function [4:0] lim_pos;
    input [2:0] port;
    input [1:0] prio;
    begin
        lim_pos = {port[2:0], prio[1:0]};
    end
endfunction

// frame class filter
function class_match;
    input [1:0] mode;
    input       bc;
    input       mc;
    input       fl;
    begin
        case (mode)
            `MODE_ALL:       class_match = 1'b1;        // see (R1)
            `MODE_BC_MC_FLD: class_match = bc | mc | fl; // see (R1)
            `MODE_BC_MC:     class_match = bc | mc;      // see (R1)
            `MODE_BC:        class_match = bc;           // see (R1)
            default:         class_match = 1'b1;
        endcase
    end
endfunction

// overhead bytes added per frame, both directions
function [4:0] overhead;
    input [7:0] ctrl;
    begin
        overhead = (ctrl[`CTRL_IFG_BIT] ? `IFG_BYTES : 5'h00)            // see (R2)
                 + (ctrl[`CTRL_PREAMBLE_BIT] ? `PREAMBLE_BYTES : 5'h00); // see (R3)
    end
endfunction

// byte count for a frame including chosen overhead
function [LEN_W:0] frame_bytes;
    input [LEN_W-1:0] len;
    input [7:0]       ctrl;
    begin
        frame_bytes = {1'b0, len} + {{(LEN_W-4){1'b0}}, overhead(ctrl)};
    end
endfunction

assign addr_phase = hsel && htrans[1] && hready;
assign off_w      = reg_off(idx_r);
assign port_w     = off_w[6:4];
assign slot_w     = off_w[3:0];
assign hit_w      = reg_hit(idx_r);

// reads take one wait state so a read right after a write sees new data
// writes never stall; data lands at the end of the data phase
assign hreadyout  = ~rd_pend_r;
assign hresp      = 1'b0;

always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
    begin
        wr_pend_r <= 1'b0;
        rd_pend_r <= 1'b0;
        idx_r     <= 8'h00;
    end
    else
    begin
        if (addr_phase)
        begin
            wr_pend_r <= hwrite;
            rd_pend_r <= ~hwrite;
            idx_r     <= haddr[9:2];
        end
        else
        begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
        end
    end
end

// read view; reserved bits and unmapped addresses read zero
// limit reads show the staged value, not the applied one
always @*
begin
    rd_value = 8'h00;
    if (hit_w && (port_w < NPORTS))
    begin
        if (slot_w == `SLOT_CTRL)
            rd_value = ctrl_r[port_w] & `CTRL_WR_MASK;
        else if (slot_w == `SLOT_PRIO3)
            rd_value = {en_r[port_w], pend_r[lim_pos(port_w, 2'h3)]};
        else
            rd_value = {1'b0, pend_r[lim_pos(port_w, slot_w[1:0] - 2'h1)]}; // see (R4) (R5)
    end
end

always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
        hrdata <= 32'h0000_0000;
    else if (rd_pend_r)
        hrdata <= {24'h00_0000, rd_value};
end

// register writes and the apply trigger
always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
    begin
        for (i = 0; i < NPORTS; i = i + 1)
        begin
            ctrl_r[i] <= `CTRL_RESET; // see (R1) (R6) (R7)
            en_r[i]   <= 1'b0;
        end
        for (i = 0; i < NLIM; i = i + 1)
        begin
            pend_r[i]    <= `LIMIT_RESET; // see (R4) (R5)
            applied_r[i] <= `LIMIT_RESET;
        end
    end
    else if (wr_pend_r && hit_w && (port_w < NPORTS))
    begin
        case (slot_w)
            `SLOT_CTRL:
                ctrl_r[port_w] <= hwdata[7:0] & `CTRL_WR_MASK;
            `SLOT_PRIO3:
            begin
                en_r[port_w]                         <= hwdata[`LIMIT_EN_BIT];
                pend_r[lim_pos(port_w, 2'h3)]        <= hwdata[6:0];
                // staged limits go live together
                applied_r[lim_pos(port_w, 2'h0)]     <= pend_r[lim_pos(port_w, 2'h0)]; // see (R8)
                applied_r[lim_pos(port_w, 2'h1)]     <= pend_r[lim_pos(port_w, 2'h1)]; // see (R8)
                applied_r[lim_pos(port_w, 2'h2)]     <= pend_r[lim_pos(port_w, 2'h2)]; // see (R8)
                applied_r[lim_pos(port_w, 2'h3)]     <= hwdata[6:0];                   // see (R8)
            end
            default:
                pend_r[lim_pos(port_w, slot_w[1:0] - 2'h1)] <= hwdata[6:0]; // see (R4) (R5)
        endcase
    end
end

// ingress accounting, one frame per cycle
// unknown ports count nothing and see a zero limit
wire              frm_ok    = frm_port < NPORTS;
wire [7:0]        frm_ctrl  = frm_ok ? ctrl_r[frm_port] : `CTRL_RESET;
wire              frm_match = frm_ok
                              && class_match(frm_ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO],
                                             frm_bcast, frm_mcast, frm_flood); // see (R9)
// port-based mode uses the priority-0 limit for every priority
wire [1:0]        frm_sel   = frm_ctrl[`CTRL_PORT_BASED_BIT] ? 2'h0 : frm_prio; // see (R6)

always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
    begin
        acct_valid     <= 1'b0;
        acct_port      <= 3'h0;
        acct_in_class  <= 1'b0;
        acct_amount    <= {(LEN_W+1){1'b0}};
        acct_limit     <= 7'h00;
        acct_limit_en  <= 1'b0;
        acct_flow_ctrl <= 1'b0;
    end
    else
    begin
        acct_valid <= frm_valid;
        if (frm_valid)
        begin
            acct_port      <= frm_port;
            acct_in_class  <= frm_match;
            acct_limit     <= frm_ok ? applied_r[lim_pos(frm_port, frm_sel)] : 7'h00;
            acct_limit_en  <= frm_ok && en_r[frm_port];
            acct_flow_ctrl <= frm_ctrl[`CTRL_FLOW_BIT];
            if (!frm_match)
                acct_amount <= {(LEN_W+1){1'b0}};                           // see (R9)
            else if (frm_ctrl[`CTRL_PACKET_BIT])
                acct_amount <= {{LEN_W{1'b0}}, 1'b1};                       // see (R7)
            else
                acct_amount <= frame_bytes(frm_len, frm_ctrl);              // see (R2) (R3)
        end
    end
end

// egress accounting shares the overhead settings
// egress on an unknown port falls back to reset settings
wire [7:0]        egr_ctrl = (egr_port < NPORTS) ? ctrl_r[egr_port] : `CTRL_RESET;

always @(posedge clock or negedge rst_b)
begin
    if (!rst_b)
    begin
        egr_acct_valid  <= 1'b0;
        egr_acct_amount <= {(LEN_W+1){1'b0}};
    end
    else
    begin
        egr_acct_valid <= egr_valid;
        if (egr_valid)
            egr_acct_amount <= frame_bytes(egr_len, egr_ctrl); // see (R2) (R3)
    end
end

endmodule // ingress_rate_limit_config

//--- bench/ingress_rate_limit_config_sva.sv
`timescale 1ns/100ps
module ingress_rate_limit_config_sva
#(
    parameter LEN_W = 11
)
(
    input wire             clock,
    input wire             rst_b,
    input wire             hsel,
    input wire [1:0]       htrans,
    input wire             hwrite,
    input wire             hready,
    input wire             hreadyout,
    input wire             hresp,
    input wire [31:0]      hrdata,
    input wire             frm_valid,
    input wire [2:0]       frm_port,
    input wire             acct_valid,
    input wire             acct_in_class,
    input wire [LEN_W:0]   acct_amount,
    input wire             egr_valid,
    input wire [LEN_W-1:0] egr_len,
    input wire             egr_acct_valid,
    input wire [LEN_W:0]   egr_acct_amount
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rd_req;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence rd_ans;
        !hreadyout ##1 hreadyout;
    endsequence
    read_wait_a: assert property (rd_req |=> rd_ans)
        else $error("read data phase not one wait state");
    write_zero_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    read_upper_a: assert property (rd_req ##1 rd_ans |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("error response seen");
    acct_pulse_a: assert property (frm_valid |=> acct_valid)
        else $error("ingress result missing");
    acct_idle_a: assert property (!frm_valid |=> !acct_valid)
        else $error("ingress result without frame");
    egr_amount_a: assert property (egr_valid |=> egr_acct_valid &&
        (egr_acct_amount - $past(egr_len)) inside {12'h000, 12'h008, 12'h00c, 12'h014})
        else $error("egress overhead wrong");
    out_class_a: assert property (acct_valid && !acct_in_class |-> acct_amount == 0)
        else $error("out of class frame counted");
    bad_port_a: assert property (frm_valid && frm_port > 3'h4 |=> !acct_in_class)
        else $error("unknown port counted");
endmodule // ingress_rate_limit_config_sva

bind ingress_rate_limit_config ingress_rate_limit_config_sva #(.LEN_W(LEN_W)) chk_u (.clock,
    .rst_b, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .frm_valid,
    .frm_port, .acct_valid, .acct_in_class, .acct_amount, .egr_valid, .egr_len,
    .egr_acct_valid, .egr_acct_amount);

//--- bench/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        clock = 0, rst_b = 0, hsel = 1, hwrite = 0, frm_valid = 0, egr_valid = 0;
    logic        bc = 0, mc = 0, fl = 0, rdy, hreadyout, hresp;
    logic        acct_valid, acct_in_class, acct_limit_en, acct_flow_ctrl, egr_acct_valid;
    logic [1:0]  htrans = 0, prio = 0;
    logic        w;
    logic [2:0]  port = 0, acct_port, f;
    logic [6:0]  acct_limit;
    logic [7:0]  c;
    logic [10:0] len = 11'h064;
    logic [11:0] acct_amount, egr_acct_amount, amt;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    // row: control byte, {bcast, mcast, flood}, expected in-class bit
    logic [11:0] rows [13] = '{12'h001, 12'h021, 12'h011, 12'h039, 12'h043, 12'h040,
        12'h085, 12'h082, 12'h0c9, 12'h0c4, 12'h250, 12'h201, 12'hff9};
    logic [7:0]  idx [4] = '{8'he7, 8'hc8, 8'hd8, 8'h00};
    int          err_total = 0, compares = 0;

    always #12.5 clock = ~clock;

    ingress_rate_limit_config dut_u (.clock, .rst_b, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .frm_valid,
        .frm_port(port), .frm_prio(prio), .frm_len(len), .frm_bcast(bc), .frm_mcast(mc),
        .frm_flood(fl), .acct_valid, .acct_port, .acct_in_class, .acct_amount, .acct_limit,
        .acct_limit_en, .acct_flow_ctrl, .egr_valid, .egr_port(port), .egr_len(len),
        .egr_acct_valid, .egr_acct_amount);

    task test_done;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // waits judged at the falling edge so the combinational ready is settled
    task bus(input [7:0] i, input w, input [7:0] d);
        htrans <= 2'h2;
        haddr <= {22'h0, i, 2'h0};
        hwrite <= w;
        do begin @(negedge clock); rdy = hreadyout; @(posedge clock); end while (rdy !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do begin @(negedge clock); rdy = hreadyout; q = hrdata; @(posedge clock); end
        while (rdy !== 1'b1);
    endtask

    task frm(input [2:0] p, input [1:0] r);
        port <= p;
        prio <= r;
        frm_valid <= 1'b1;
        egr_valid <= 1'b1;
        @(posedge clock);
        frm_valid <= 1'b0;
        egr_valid <= 1'b0;
        @(negedge clock);
        chk({acct_valid, egr_acct_valid}, 2'h3);
        @(posedge clock);
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (idx[k])
        begin
            bus(idx[k], 0, 0);
            chk(q, 0);
            bus(idx[k], 1, 8'hff);
            bus(idx[k], 0, 0);
            chk(q, idx[k] ? 32'h7f : 0);
        end
        foreach (rows[k])
        begin
            {c, f, w} = rows[k];
            bus(8'hb6, 1, c);
            bus(8'hb6, 0, 0);
            chk(q, c & 8'h7f);
            {bc, mc, fl} <= f;
            len <= {c, f};
            frm(0, 0);
            amt = {1'b0, c, f} + (c[1] ? 12'h00c : 0) + (c[0] ? 12'h008 : 0);
            chk(egr_acct_amount, amt);
            chk(acct_in_class, w);
            chk(acct_amount, w ? (c[5] ? 1 : amt) : 0);
            chk(acct_flow_ctrl, c[4]);
            chk(acct_port, 0);
        end
        bus(8'hb6, 1, 0);
        bus(8'hb7, 1, 8'h25);
        frm(0, 0);
        chk(acct_limit, 0);
        bus(8'hba, 1, 8'h80);
        frm(0, 0);
        chk({acct_limit_en, acct_limit}, 8'ha5);
        frm(0, 2);
        chk(acct_limit, 0);
        bus(8'hb6, 1, 8'h40);
        frm(0, 2);
        chk(acct_limit, 7'h25);
        frm(5, 0);
        chk(acct_amount, 0);
        chk(acct_port, 5);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        bus(8'hb6, 0, 0);
        chk(q, 0);
        bus(8'hb7, 0, 0);
        chk(q, 0);
        frm(0, 0);
        chk({acct_limit_en, acct_limit}, 0);
        test_done;
    end

    // whole run needs about 170 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        err_total++;
        test_done;
    end
endmodule // tb_top
